// >>> rtl/nfhc_defs.vh
// Constants for the NAND erase/identify/status/reset host controller
`ifndef NFHC_DEFS_VH
`define NFHC_DEFS_VH
`define NFHC_CMD_ERASE_SETUP 8'h60
`define NFHC_CMD_ERASE_CONF 8'hd0
`define NFHC_CMD_READ_ID 8'h90
`define NFHC_CMD_STATUS 8'h70
`define NFHC_CMD_STATUS_PLANE 8'h78
`define NFHC_CMD_RESET 8'hff
`define NFHC_CMD_READ_MODE 8'h00
`define NFHC_ID_ADDR_JEDEC 8'h00
`define NFHC_ID_ADDR_ONFI 8'h20
`define NFHC_ID_LEN_JEDEC 3'd5
`define NFHC_ID_LEN_ONFI 3'd4
`define NFHC_ROW_CYCLES 2'd3
`define NFHC_STATUS_RESET_VAL 8'he0
`define NFHC_SR_PASS_FAIL 0
`define NFHC_SR_CACHE_PF 1
`define NFHC_SR_CORE_READY 5
`define NFHC_SR_READY 6
`define NFHC_SR_WP_N 7
`define NFHC_OP_ERASE 3'd0
`define NFHC_OP_READ_ID 3'd1
`define NFHC_OP_STATUS 3'd2
`define NFHC_OP_STATUS_PLANE 3'd3
`define NFHC_OP_RESET 3'd4
`define NFHC_OP_READ_MODE 3'd5
`define NFHC_T_STROBE_NS 25
`define NFHC_CLK_NS 5
`define NFHC_STROBE_CYC ((`NFHC_T_STROBE_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS)
`endif

// >>> rtl/nfhc_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module nfhc_sync #(
   parameter RESET_VAL = 1'b1
) (
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // Pin in, filtered level out
   input wire pin,
   output reg level_q
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s1_q <= RESET_VAL;
         s2_q <= RESET_VAL;
         s3_q <= RESET_VAL;
         level_q <= RESET_VAL;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // Change counts only once stages two and three agree
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end
endmodule

// >>> rtl/nfhc_ctrl.v
// Host controller issuing erase, identify, status and reset to a NAND device
`timescale 1ns/1ps
`include "nfhc_defs.vh"
module nfhc_ctrl #(
   parameter STROBE_CYC = `NFHC_STROBE_CYC
) (
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // User command port
   input wire req_valid,
   output wire req_ready,
   input wire [2:0] req_op,
   input wire [23:0] req_row,
   input wire req_onfi,
   output reg rsp_valid_q,
   output reg [7:0] rsp_data_q,
   output reg rsp_last_q,
   output reg op_busy_q,
   output reg erase_failed_q,
   // Device pins
   output reg chip_enable_n_q,
   output reg cmd_latch_q,
   output reg addr_latch_q,
   output reg write_strobe_n_q,
   output reg read_strobe_n_q,
   output reg [7:0] io_out_q,
   output wire io_oe_n,
   input wire [7:0] io_in,
   input wire ready_busy_n
);
   localparam ST_IDLE = 3'd0;
   localparam ST_CMD = 3'd1;
   localparam ST_ADDR = 3'd2;
   localparam ST_CONF = 3'd3;
   localparam ST_WAIT = 3'd4;
   localparam ST_READ = 3'd5;
   localparam ST_DONE = 3'd6;
   reg [2:0] state_q;
   reg [2:0] op_q;
   reg [23:0] row_q;
   reg onfi_q;
   reg [1:0] addr_cnt_q;
   reg [2:0] byte_cnt_q;
   reg [2:0] byte_total_q;
   reg [7:0] tmr_q;
   reg phase_q;
   reg drive_q;
   reg stat_after_q;
   wire rb_ready;
   wire [7:0] io_sync;
   wire tick = (tmr_q == 8'h00);
   assign io_oe_n = ~drive_q;
   // req_ready low while device shows busy; ST_IDLE still takes req_valid without it
   assign req_ready = (state_q == ST_IDLE) && rb_ready;
   // Assume busy out of reset, so req_ready stays low through power-on busy
   nfhc_sync #(
      .RESET_VAL(1'b0)
   ) u_rb_sync (
      .core_clk(core_clk),
      .rst(rst),
      .pin(ready_busy_n),
      .level_q(rb_ready)
   );
   // Bus is a pin; sync costs four cycles, so STROBE_CYC must be 4 or more
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_io_sync
         nfhc_sync #(
            .RESET_VAL(1'b1)
         ) u_io_sync (
            .core_clk(core_clk),
            .rst(rst),
            .pin(io_in[gi]),
            .level_q(io_sync[gi])
         );
      end
   endgenerate
   function [7:0] op_cmd;
      input [2:0] op;
      begin
         case (op)
            `NFHC_OP_ERASE: op_cmd = `NFHC_CMD_ERASE_SETUP;
            `NFHC_OP_READ_ID: op_cmd = `NFHC_CMD_READ_ID;
            `NFHC_OP_STATUS: op_cmd = `NFHC_CMD_STATUS;
            `NFHC_OP_STATUS_PLANE: op_cmd = `NFHC_CMD_STATUS_PLANE;
            `NFHC_OP_RESET: op_cmd = `NFHC_CMD_RESET;
            default: op_cmd = `NFHC_CMD_READ_MODE;
         endcase
      end
   endfunction
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         op_q <= 3'd0;
         row_q <= 24'h000000;
         onfi_q <= 1'b0;
         addr_cnt_q <= 2'd0;
         byte_cnt_q <= 3'd0;
         byte_total_q <= 3'd0;
         tmr_q <= 8'h00;
         phase_q <= 1'b0;
         drive_q <= 1'b0;
         stat_after_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         rsp_data_q <= 8'h00;
         rsp_last_q <= 1'b0;
         op_busy_q <= 1'b0;
         erase_failed_q <= 1'b0;
         chip_enable_n_q <= 1'b1;
         cmd_latch_q <= 1'b0;
         addr_latch_q <= 1'b0;
         write_strobe_n_q <= 1'b1;
         read_strobe_n_q <= 1'b1;
         io_out_q <= 8'h00;
      end else begin
         rsp_valid_q <= 1'b0;
         rsp_last_q <= 1'b0;
         if (!tick) begin
            tmr_q <= tmr_q - 8'h01;
         end
         case (state_q)
            ST_IDLE: begin
               if (req_valid) begin
                  op_q <= req_op;
                  row_q <= req_row;
                  onfi_q <= req_onfi;
                  stat_after_q <= 1'b0;
                  chip_enable_n_q <= 1'b0;
                  op_busy_q <= 1'b1;
                  state_q <= ST_CMD;
                  phase_q <= 1'b0;
                  tmr_q <= STROBE_CYC[7:0];
               end else begin
                  chip_enable_n_q <= 1'b1;
               end
            end
            ST_CMD: if (tick) begin
               if (!phase_q) begin
                  cmd_latch_q <= 1'b1;
                  drive_q <= 1'b1;
                  write_strobe_n_q <= 1'b0;
                  io_out_q <= stat_after_q ? `NFHC_CMD_STATUS : op_cmd(op_q);
                  phase_q <= 1'b1;
               end else begin
                  // Latch stays high past the rising strobe
                  write_strobe_n_q <= 1'b1;
                  phase_q <= 1'b0;
                  addr_cnt_q <= 2'd0;
                  byte_cnt_q <= 3'd0;
                  if (stat_after_q) begin
                     byte_total_q <= 3'd1;
                     state_q <= ST_READ;
                  end else begin
                     case (op_q)
                        // row cycles pick block or plane; read ID sends one ID address cycle
                        `NFHC_OP_ERASE, `NFHC_OP_STATUS_PLANE, `NFHC_OP_READ_ID:
                           state_q <= ST_ADDR;
                        `NFHC_OP_STATUS: begin
                           byte_total_q <= 3'd1;
                           state_q <= ST_READ;
                        end
                        `NFHC_OP_RESET: state_q <= ST_WAIT;
                        default: state_q <= ST_DONE;
                     endcase
                  end
               end
               tmr_q <= STROBE_CYC[7:0];
            end
            ST_ADDR: if (tick) begin
               if (!phase_q) begin
                  cmd_latch_q <= 1'b0;
                  addr_latch_q <= 1'b1;
                  write_strobe_n_q <= 1'b0;
                  if (op_q == `NFHC_OP_READ_ID) begin
                     io_out_q <= onfi_q ? `NFHC_ID_ADDR_ONFI : `NFHC_ID_ADDR_JEDEC;
                  end else begin
                     io_out_q <= row_q[8 * addr_cnt_q +: 8];
                  end
                  phase_q <= 1'b1;
               end else begin
                  write_strobe_n_q <= 1'b1;
                  phase_q <= 1'b0;
                  addr_cnt_q <= addr_cnt_q + 2'd1;
                  if (op_q == `NFHC_OP_READ_ID) begin
                     byte_total_q <= onfi_q ? `NFHC_ID_LEN_ONFI : `NFHC_ID_LEN_JEDEC;
                     state_q <= ST_READ;
                  end else if (addr_cnt_q == `NFHC_ROW_CYCLES - 2'd1) begin
                     if (op_q == `NFHC_OP_ERASE) begin
                        state_q <= ST_CONF;
                     end else begin
                        byte_total_q <= 3'd1;
                        state_q <= ST_READ;
                     end
                  end
               end
               tmr_q <= STROBE_CYC[7:0];
            end
            ST_CONF: if (tick) begin
               if (!phase_q) begin
                  addr_latch_q <= 1'b0;
                  cmd_latch_q <= 1'b1;
                  write_strobe_n_q <= 1'b0;
                  io_out_q <= `NFHC_CMD_ERASE_CONF;
                  phase_q <= 1'b1;
               end else begin
                  write_strobe_n_q <= 1'b1;
                  phase_q <= 1'b0;
                  state_q <= ST_WAIT;
               end
               tmr_q <= STROBE_CYC[7:0];
            end
            // hold off while busy pin low
            ST_WAIT: begin
               drive_q <= 1'b0;
               cmd_latch_q <= 1'b0;
               addr_latch_q <= 1'b0;
               if (tick && rb_ready) begin
                  if (op_q == `NFHC_OP_ERASE) begin
                     stat_after_q <= 1'b1;
                     state_q <= ST_CMD;
                  end else begin
                     state_q <= ST_DONE;
                  end
               end
            end
            ST_READ: begin
               drive_q <= 1'b0;
               cmd_latch_q <= 1'b0;
               addr_latch_q <= 1'b0;
               if (tick) begin
                  if (!phase_q) begin
                     read_strobe_n_q <= 1'b0;
                     phase_q <= 1'b1;
                  end else begin
                     // Sample just before the rising strobe
                     read_strobe_n_q <= 1'b1;
                     phase_q <= 1'b0;
                     rsp_valid_q <= 1'b1;
                     rsp_data_q <= io_sync;
                     byte_cnt_q <= byte_cnt_q + 3'd1;
                     if (stat_after_q) begin
                        erase_failed_q <= io_sync[`NFHC_SR_PASS_FAIL];
                     end
                     if (byte_cnt_q == byte_total_q - 3'd1) begin
                        rsp_last_q <= 1'b1;
                        state_q <= ST_DONE;
                     end
                  end
                  tmr_q <= STROBE_CYC[7:0];
               end
            end
            ST_DONE: begin
               drive_q <= 1'b0;
               cmd_latch_q <= 1'b0;
               addr_latch_q <= 1'b0;
               // own chip enable frames each request
               chip_enable_n_q <= 1'b1;
               op_busy_q <= 1'b0;
               state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule

// >>> testbench/nfhc_ctrl_sva.sv
// Port assertions for the NAND host controller
`timescale 1ns/1ps
module nfhc_ctrl_sva #(
   parameter STROBE_CYC = 5
) (
   // Clock, reset and user side
   input wire core_clk,
   input wire rst,
   input wire req_valid,
   input wire req_ready,
   input wire rsp_valid_q,
   input wire rsp_last_q,
   input wire op_busy_q,
   // Device pins
   input wire chip_enable_n_q,
   input wire cmd_latch_q,
   input wire addr_latch_q,
   input wire write_strobe_n_q,
   input wire read_strobe_n_q,
   input wire io_oe_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   reg [7:0] we_cnt_q;
   // Counts low cycles of the write strobe
   always @(posedge core_clk or posedge rst) begin
      if (rst)
         we_cnt_q <= 8'h00;
      else
         we_cnt_q <= write_strobe_n_q ? 8'h00 : we_cnt_q + 8'h01;
   end
   sequence s_accept;
      req_valid && req_ready;
   endsequence
   sequence s_read_edge;
      $rose(read_strobe_n_q);
   endsequence
   a_accept_busy: assert property (s_accept |=> op_busy_q)
      else $error("busy not raised after accept");
   a_busy_refuse: assert property (op_busy_q |-> !req_ready)
      else $error("ready while busy");
   a_rsp_on_read: assert property (rsp_valid_q |-> s_read_edge)
      else $error("byte without read strobe edge");
   a_rsp_pulse: assert property (rsp_valid_q |=> !rsp_valid_q)
      else $error("byte valid longer than one cycle");
   a_last_valid: assert property (rsp_last_q |-> rsp_valid_q)
      else $error("last without byte");
   a_idle_ce: assert property (!op_busy_q |-> chip_enable_n_q)
      else $error("chip enabled while idle");
   a_latch_excl: assert property (!(cmd_latch_q && addr_latch_q))
      else $error("both latches high");
   a_drive_write: assert property (!write_strobe_n_q |-> !io_oe_n)
      else $error("bus not driven during write");
   a_float_read: assert property (!read_strobe_n_q |-> io_oe_n && !cmd_latch_q)
      else $error("bus driven during read");
   a_we_width: assert property ($rose(write_strobe_n_q) |-> we_cnt_q == STROBE_CYC + 1)
      else $error("write strobe width wrong");
   a_latch_hold: assert property ($rose(write_strobe_n_q) |->
      $stable(cmd_latch_q) && $stable(addr_latch_q))
      else $error("latch moved with rising write strobe");
endmodule
bind nfhc_ctrl nfhc_ctrl_sva #(.STROBE_CYC(STROBE_CYC)) nfhc_ctrl_sva_i (.core_clk, .rst,
   .req_valid, .req_ready, .rsp_valid_q, .rsp_last_q, .op_busy_q, .chip_enable_n_q,
   .cmd_latch_q, .addr_latch_q, .write_strobe_n_q, .read_strobe_n_q, .io_oe_n);

// >>> testbench/nfhc_dev_model.sv
// Behavioural NAND device for erase, identify, status and reset
`timescale 1ns/1ps
module nfhc_dev_model #(
   parameter [7:0] MAKER_ID = 8'h5a,
   parameter [7:0] PART_ID = 8'h3c,
   parameter BUSY_NS = 300
) (
   // Pins
   input wire ce_n,
   input wire cle,
   input wire ale,
   input wire we_n,
   input wire re_n,
   input wire [7:0] io,
   output wire [7:0] dq,
   output reg rb_n,
   // Fault injection
   input wire fail
);
   // Identity bytes are arbitrary
   reg [7:0] cmd_q = 8'h00, addr_q = 8'h00, last_q = 8'h00;
   reg [23:0] row_q = 24'h0, erased_row_q = 24'h0;
   reg [2:0] ptr_q = 3'd0;
   reg fail_q = 1'b0;
   event go_busy;
   wire [39:0] id_w = addr_q == 8'h20 ? 40'h4f4e464900 : {MAKER_ID, PART_ID, 24'h901507};
   wire [7:0] byte_w;
   assign byte_w = cmd_q == 8'h90 ? id_w[39 - 8 * ptr_q -: 8] : {1'b1, rb_n, rb_n, 4'h0, fail_q};
   assign dq = (!ce_n && !re_n) ? byte_w : ~last_q;
   wire take = rb_n || io == 8'h70 || io == 8'h78 || (io == 8'hff && cmd_q != 8'hff);
   initial rb_n = 1'b1;
   always @(posedge we_n) begin
      if (!ce_n && cle && take) begin
         cmd_q <= io;
         ptr_q <= 3'd0;
         if (io == 8'hd0) begin
            erased_row_q <= row_q;
            fail_q <= fail;
            -> go_busy;
         end
         if (io == 8'hff) begin
            fail_q <= 1'b0;
            -> go_busy;
         end
      end else if (!ce_n && ale) begin
         row_q <= {io, row_q[23:8]};
         addr_q <= io;
      end
   end
   always @(posedge re_n) begin
      if (!ce_n) begin
         last_q <= byte_w;
         ptr_q <= ptr_q + 3'd1;
      end
   end
   always @(go_busy) begin
      rb_n = 1'b0;
      #(BUSY_NS) rb_n = 1'b1;
   end
endmodule

// >>> testbench/test_nfhc_ctrl.sv
// Self-checking bench for the NAND host controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module test_nfhc_ctrl;
   reg core_clk = 0, rst = 1, req_valid = 0, req_onfi = 0, fail = 0, saw_busy = 0;
   reg [2:0] req_op = 0;
   reg [23:0] req_row = 0;
   wire req_ready, rsp_valid_q, rsp_last_q, op_busy_q, erase_failed_q, ce_n, cle, ale;
   wire we_n, re_n, io_oe_n, rb_n;
   wire [7:0] rsp_data_q, io_out_q, dq;
   wire [7:0] io_in = io_oe_n ? dq : io_out_q;
   int n_errors = 0, comparisons = 0, nb = 0, last_idx = 0;
   reg [7:0] got [0:7];
   nfhc_ctrl nfhc_ctrl_i (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
      .req_ready(req_ready), .req_op(req_op), .req_row(req_row), .req_onfi(req_onfi),
      .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q), .rsp_last_q(rsp_last_q),
      .op_busy_q(op_busy_q), .erase_failed_q(erase_failed_q), .chip_enable_n_q(ce_n),
      .cmd_latch_q(cle), .addr_latch_q(ale), .write_strobe_n_q(we_n),
      .read_strobe_n_q(re_n), .io_out_q(io_out_q), .io_oe_n(io_oe_n), .io_in(io_in),
      .ready_busy_n(rb_n));
   nfhc_dev_model nfhc_dev_model_i (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
      .re_n(re_n), .io(io_in), .dq(dq), .rb_n(rb_n), .fail(fail));
   initial forever #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (rb_n === 1'b0) saw_busy = 1;
      if (rsp_valid_q === 1'b1) begin
         got[nb % 8] = rsp_data_q;
         if (rsp_last_q === 1'b1) last_idx = nb;
         nb++;
      end
   end
   task automatic run(input [2:0] op, input [23:0] row, input onfi);
      int t;
      t = 0;
      nb = 0;
      @(posedge core_clk);
      #1 {req_op, req_row, req_onfi, req_valid} = {op, row, onfi, 1'b1};
      while (req_ready !== 1'b1) begin
         @(posedge core_clk);
         #1;
      end
      @(posedge core_clk);
      #1 req_valid = 0;
      while (op_busy_q !== 1'b0 && t < 5000) begin
         @(posedge core_clk);
         #1;
         t++;
      end
      if (t == 5000) begin
         $display("[ERR] op_busy_q expected 0 seen 1");
         n_errors++;
      end
      $display("op %0d done, %0d bytes", op, nb);
   endtask
   task end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #200000;
      n_errors++;
      end_of_test;
   end
   initial begin
      reg [39:0] exp_id;
      reg [31:0] exp_onfi;
      exp_id = {8'h5a, 8'h3c, 8'h90, 8'h15, 8'h07};
      exp_onfi = {8'h4f, 8'h4e, 8'h46, 8'h49};
      repeat (8) @(posedge core_clk);
      #1 rst = 0;
      run(2, 0, 0);
      `CHK("status after power-up", 8'he0, got[0])
      run(1, 0, 0);
      for (int i = 0; i < 5; i++) `CHK("id byte", exp_id[39 - 8 * i -: 8], got[i])
      `CHK("id count", 5, nb)
      `CHK("id last", 4, last_idx)
      run(1, 0, 1);
      for (int i = 0; i < 4; i++) `CHK("onfi byte", exp_onfi[31 - 8 * i -: 8], got[i])
      `CHK("onfi last", 3, last_idx)
      run(0, 24'h0a0b0c, 0);
      `CHK("erased row", 24'h0a0b0c, nfhc_dev_model_i.erased_row_q)
      `CHK("busy seen", 1'b1, saw_busy)
      `CHK("erase result", 1'b0, erase_failed_q)
      fail = 1;
      run(0, 24'h123456, 0);
      fail = 0;
      `CHK("erase fail", 1'b1, erase_failed_q)
      run(2, 0, 0);
      `CHK("status fail", 8'he1, got[0])
      run(3, 24'h123456, 0);
      `CHK("plane status", 8'he1, got[0])
      run(4, 0, 0);
      run(2, 0, 0);
      `CHK("status after reset", 8'he0, got[0])
      run(5, 0, 0);
      `CHK("read mode bytes", 0, nb)
      end_of_test;
   end
endmodule
